// ==== src/csi_rx_mon_cfg.svh ====
// Register indices, field positions and reset values of the receive error monitor.
// Assumes a 32-bit word-aligned register bus; byte address is four times the index.
`ifndef CSI_RX_MON_CFG_SVH
`define CSI_RX_MON_CFG_SVH

`define IDX_PACKET_ERROR_COUNTER 8'h5c
`define IDX_PACKET_ERROR_FLAGS 8'h5d
`define IDX_LANES_LOW_PAIR 8'h5e
`define IDX_LANES_HIGH_PAIR 8'h5f
`define IDX_CLOCK_LANE 8'h60
`define IDX_HEADER_CHANNEL_TYPE 8'h61
`define IDX_HEADER_WC_LOW 8'h62
`define IDX_HEADER_WC_HIGH 8'h63
`define IDX_HEADER_ECC 8'h64
`define IDX_IRQ_STATUS 8'h65
`define IDX_IRQ_MASK 8'h66

`define ERR_COUNT_MAX 8'hff
`define REG_RESET 8'h00
`define IRQ_RESET 7'h00

`define BIT_SHORT_LINE 3
`define BIT_PAYLOAD_SUM 2
`define BIT_HEADER_DOUBLE 1
`define BIT_HEADER_SINGLE 0
`define BIT_CLOCK_LANE_CTRL 1
`define BIT_LEN_CHANGE 7

`define IRQ_BIT_LANE 4
`define IRQ_BIT_CLOCK_LANE 5
`define IRQ_BIT_COUNTED 6
`define IRQ_WIDTH 7

`endif

// ==== src/csi_rx_mon_pkg.sv ====
// Types shared by the receive error monitor and its bench.
// Assumes the constants header is included beside it.
package csi_rx_mon_pkg;

    // One sample of the receiver's report, valid at each rising link clock edge.
    typedef struct packed {
        logic hdr_valid;
        logic [1:0] vc;
        logic [5:0] dt;
        logic [15:0] wc;
        logic [5:0] ecc;
        logic pkt_err;
        logic short_line;
        logic payload_sum;
        logic hdr_double;
        logic hdr_single;
        logic len_change;
        logic [3:0] sync_single;
        logic [3:0] sync_multi;
        logic [3:0] req_ctrl;
        logic clk_ctrl;
    } link_event_type;

    typedef struct packed {
        link_event_type ev_s1;
        link_event_type ev_s2;
        logic lclk_s1;
        logic lclk_s2;
        logic lclk_s3;
        logic [7:0] err_count;
        logic [3:0] pkt_flags;
        logic [3:0] lane_single;
        logic [3:0] lane_multi;
        logic [3:0] lane_ctrl;
        logic clk_flag;
        logic [1:0] chan;
        logic [5:0] dtype;
        logic [7:0] wc_lo;
        logic [7:0] wc_hi;
        logic len_change;
        logic [5:0] ecc;
        logic [6:0] irq_status;
        logic [6:0] irq_mask;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic irq;
    } mon_state_type;

endpackage

// ==== src/csi_rx_error_monitor.sv ====
// Error counting, fault flags and header capture for the camera serial receive port, as an AHB-Lite slave.
// Assumes the receiver reports one sample per rising link_clk edge, stable around that edge.
//
// Behaviour
// - Eight-bit error packet counter, reset zero.
// - Counter read returns count, then restarts.
// - Bit 3 flags short line, clear-on-read.
// - Bit 2 flags payload checksum fault, clear-on-read.
// - Bit 1 flags header double ECC fault.
// - Bit 0 flags single ECC fault; 7:4 zero.
// - Per lane: single-bit sync fault flag.
// - Per lane: multi-bit sync fault flag.
// - Per lane: control fault in request state.
// - Two lanes per register, bits 4,0 zero.
// - Clock lane control fault in bit 1.
// - Virtual channel captured into bits 7:6.
// - Data type captured into bits 5:0.
// - Word count low byte captured separately.
// - Word count high byte captured separately.
// - Header ECC stored in bits 5:0.
// - Line length change sets bit 7.
`timescale 1ns/1ps
`include "csi_rx_mon_cfg.svh"

module csi_rx_error_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic link_clk,
    input wire csi_rx_mon_pkg::link_event_type link_in
);
    import csi_rx_mon_pkg::*;

    mon_state_type r;
    mon_state_type r_nxt;

    // Register index of a bus address; the two byte bits are dropped.
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        reg_index = a[9:2];
    endfunction

    // Packs two lanes as single, multi, control with a zero bit under each triple.
    function automatic logic [7:0] pack_pair(input logic [1:0] s, input logic [1:0] m, input logic [1:0] c);
        pack_pair = {s[1], m[1], c[1], 1'b0, s[0], m[0], c[0], 1'b0};
    endfunction

    logic accept;
    logic rd_acc;
    logic [7:0] acc_idx;
    logic link_edge;
    link_event_type ev;
    logic [7:0] rd_val;
    logic [7:0] status_val;
    logic [6:0] irq_set;

    always_comb begin
        r_nxt = r;
        accept = hsel & hready & htrans[1];
        rd_acc = accept & ~hwrite;
        acc_idx = reg_index(haddr);
        ev = r.ev_s2;

        // Only the second stage is read; the first stage feeds nothing else.
        r_nxt.ev_s1 = link_in;
        r_nxt.ev_s2 = r.ev_s1;
        r_nxt.lclk_s1 = link_clk;
        r_nxt.lclk_s2 = r.lclk_s1;
        r_nxt.lclk_s3 = r.lclk_s2;
        // The link clock runs well below hclk, so one sample per synchronised rising edge is enough.
        link_edge = r.lclk_s2 & ~r.lclk_s3;

        status_val = {4'h0, r.pkt_flags};
        case (acc_idx)
            `IDX_PACKET_ERROR_COUNTER: rd_val = r.err_count;
            `IDX_PACKET_ERROR_FLAGS: rd_val = status_val;
            `IDX_LANES_LOW_PAIR: rd_val = pack_pair(r.lane_single[1:0], r.lane_multi[1:0], r.lane_ctrl[1:0]);
            `IDX_LANES_HIGH_PAIR: rd_val = pack_pair(r.lane_single[3:2], r.lane_multi[3:2], r.lane_ctrl[3:2]);
            `IDX_CLOCK_LANE: rd_val = {6'h00, r.clk_flag, 1'b0};
            `IDX_HEADER_CHANNEL_TYPE: rd_val = {r.chan, r.dtype};
            `IDX_HEADER_WC_LOW: rd_val = r.wc_lo;
            `IDX_HEADER_WC_HIGH: rd_val = r.wc_hi;
            `IDX_HEADER_ECC: rd_val = {r.len_change, 1'b0, r.ecc};
            `IDX_IRQ_STATUS: rd_val = {1'b0, r.irq_status};
            `IDX_IRQ_MASK: rd_val = {1'b0, r.irq_mask};
            default: rd_val = 8'h00;
        endcase

        // Zero-wait slave: data for a read is registered at the address phase edge.
        r_nxt.hreadyout = 1'b1;
        r_nxt.hrdata = rd_acc ? {24'h000000, rd_val} : 32'h00000000;
        r_nxt.wr_pend = accept & hwrite;
        r_nxt.wr_idx = acc_idx;

        // Read side effects land on the address phase edge; events in the same cycle are applied after.
        if (rd_acc && acc_idx == `IDX_PACKET_ERROR_COUNTER) begin
            r_nxt.err_count = `REG_RESET;
        end
        if (rd_acc && acc_idx == `IDX_PACKET_ERROR_FLAGS) begin
            r_nxt.pkt_flags = 4'h0;
        end
        if (rd_acc && acc_idx == `IDX_LANES_LOW_PAIR) begin
            r_nxt.lane_single[1:0] = 2'h0;
            r_nxt.lane_multi[1:0] = 2'h0;
            r_nxt.lane_ctrl[1:0] = 2'h0;
        end
        if (rd_acc && acc_idx == `IDX_LANES_HIGH_PAIR) begin
            r_nxt.lane_single[3:2] = 2'h0;
            r_nxt.lane_multi[3:2] = 2'h0;
            r_nxt.lane_ctrl[3:2] = 2'h0;
        end
        if (rd_acc && acc_idx == `IDX_CLOCK_LANE) begin
            r_nxt.clk_flag = 1'b0;
        end
        if (rd_acc && acc_idx == `IDX_HEADER_ECC) begin
            r_nxt.len_change = 1'b0;
        end

        // Write data arrives in the data phase, one cycle after the address.
        if (r.wr_pend && r.wr_idx == `IDX_IRQ_STATUS) begin
            r_nxt.irq_status = r.irq_status & ~hwdata[6:0];
        end
        if (r.wr_pend && r.wr_idx == `IDX_IRQ_MASK) begin
            r_nxt.irq_mask = hwdata[6:0];
        end

        irq_set = 7'h00;
        if (link_edge) begin
            if (ev.pkt_err) begin
                // Saturating keeps a burst of errors from wrapping to a small count.
                if (r_nxt.err_count != `ERR_COUNT_MAX) begin
                    r_nxt.err_count = r_nxt.err_count + 8'h01;
                end
                irq_set[`IRQ_BIT_COUNTED] = 1'b1;
            end
            r_nxt.pkt_flags[`BIT_SHORT_LINE] = r_nxt.pkt_flags[`BIT_SHORT_LINE] | ev.short_line;
            r_nxt.pkt_flags[`BIT_PAYLOAD_SUM] = r_nxt.pkt_flags[`BIT_PAYLOAD_SUM] | ev.payload_sum;
            r_nxt.pkt_flags[`BIT_HEADER_DOUBLE] = r_nxt.pkt_flags[`BIT_HEADER_DOUBLE] | ev.hdr_double;
            r_nxt.pkt_flags[`BIT_HEADER_SINGLE] = r_nxt.pkt_flags[`BIT_HEADER_SINGLE] | ev.hdr_single;
            r_nxt.lane_single = r_nxt.lane_single | ev.sync_single;
            r_nxt.lane_multi = r_nxt.lane_multi | ev.sync_multi;
            r_nxt.lane_ctrl = r_nxt.lane_ctrl | ev.req_ctrl;
            r_nxt.clk_flag = r_nxt.clk_flag | ev.clk_ctrl;
            r_nxt.len_change = r_nxt.len_change | ev.len_change;
            if (ev.hdr_valid) begin
                r_nxt.chan = ev.vc;
                r_nxt.dtype = ev.dt;
                r_nxt.wc_lo = ev.wc[7:0];
                r_nxt.wc_hi = ev.wc[15:8];
                r_nxt.ecc = ev.ecc;
            end
            irq_set[3:0] = {ev.short_line, ev.payload_sum, ev.hdr_double, ev.hdr_single};
            irq_set[`IRQ_BIT_LANE] = |{ev.sync_single, ev.sync_multi, ev.req_ctrl};
            irq_set[`IRQ_BIT_CLOCK_LANE] = ev.clk_ctrl;
        end
        // A new event wins over a write-one-to-clear in the same cycle.
        r_nxt.irq_status = r_nxt.irq_status | irq_set;
        r_nxt.irq = |(r_nxt.irq_status & r_nxt.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.hreadyout <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end

    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign irq = r.irq;

endmodule

// ==== verification/csi_rx_mon_check_monitor.sv ====
// Bus-side checker for the receive error monitor.
// Assumes it is bound to the monitor and sees only its ports.
`timescale 1ns/1ps
module csi_rx_mon_check (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_s(logic [7:0] idx);
        hsel && hready && htrans[1] && !hwrite && haddr[9:2] == idx;
    endsequence
    sequence any_rd_s;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    ready_high_a: assert property (hreadyout) else $error("wait state seen");
    resp_okay_a: assert property (!hresp) else $error("error response seen");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper data set");
    idle_data_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
        else $error("data outside read");
    flags_rsvd_a: assert property (rd_s(8'h5d) |=> hrdata[7:4] == 4'h0) else $error("flag spare set");
    lane_rsvd_a: assert property (rd_s(8'h5e) or rd_s(8'h5f) |=> !hrdata[4] && !hrdata[0])
        else $error("lane spare set");
    clk_rsvd_a: assert property (rd_s(8'h60) |=> hrdata[7:2] == 6'h0 && !hrdata[0])
        else $error("clock spare set");
    ecc_rsvd_a: assert property (rd_s(8'h64) |=> !hrdata[6]) else $error("ecc spare set");
endmodule
bind csi_rx_error_monitor csi_rx_mon_check u_check (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

// ==== verification/csi_sensor_model.sv ====
// Behavioural image sensor giving one receiver report per link clock pulse.
// Assumes the monitor samples the report at the rising link clock edge.
`timescale 1ns/1ps
module csi_sensor_model (
    output logic link_clk,
    output csi_rx_mon_pkg::link_event_type link_in
);
    import csi_rx_mon_pkg::*;
    initial begin
        link_clk = 1'b0;
        link_in = '0;
    end
    // The clock stands still between reports, and the lines then carry garbage.
    task automatic send(input link_event_type ev);
        link_in = ev;
        #100 link_clk = 1'b1;
        #100 link_clk = 1'b0;
        link_in = ~ev;
    endtask
endmodule

// ==== verification/csi_rx_error_monitor_bench.sv ====
// Self-checking bench for the receive error monitor.
// Assumes the sensor model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`include "csi_rx_mon_cfg.svh"
module csi_rx_error_monitor_bench;
    import csi_rx_mon_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, link_clk;
    logic [31:0] haddr, hwdata, hrdata, d, rd_q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    link_event_type link_in, ev;
    int bad_count, compares, i, k;
    csi_rx_error_monitor u_csi_rx_error_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link_clk(link_clk), .link_in(link_in));
    csi_sensor_model u_csi_sensor_model (.link_clk(link_clk), .link_in(link_in));
    // Read data as it stood before each rising edge, so the data phase value is not lost to the edge race.
    always @(posedge hclk) rd_q <= hrdata;
    task automatic test_done();
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 16; n++) begin
            @(posedge hclk);
            #1;
            if (hreadyout === 1'b1) return;
        end
        bad_count++;
        $display("[FAIL] %0t bus hang", $time);
        test_done();
    endtask
    // Entered just after a rising edge; returns at the edge that ends the data phase.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        d = rd_q;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(d, exp);
    endtask
    task automatic ev_send();
        u_csi_sensor_model.send(ev);
        @(posedge hclk);
    endtask
    task automatic reset_values();
        for (i = 'h5c; i <= 'h66; i++) rdc(i[7:0], 32'h0);
        bus(1'b1, 8'h70, 32'hff);
        bus(1'b1, `IDX_HEADER_CHANNEL_TYPE, 32'hff);
        rdc(8'h70, 32'h0);
        rdc(`IDX_HEADER_CHANNEL_TYPE, 32'h0);
    endtask
    task automatic count_test();
        ev = '0;
        ev.pkt_err = 1'b1;
        for (i = 0; i < 3; i++) ev_send();
        rdc(`IDX_PACKET_ERROR_COUNTER, 32'h3);
        rdc(`IDX_PACKET_ERROR_COUNTER, 32'h0);
        for (i = 0; i < 257; i++) ev_send();
        rdc(`IDX_PACKET_ERROR_COUNTER, 32'hff);
        rdc(`IDX_PACKET_ERROR_COUNTER, 32'h0);
    endtask
    task automatic flag_test();
        for (i = 0; i < 4; i++) begin
            ev = '0;
            {ev.short_line, ev.payload_sum, ev.hdr_double, ev.hdr_single} = 4'h1 << i;
            ev_send();
            rdc(`IDX_PACKET_ERROR_FLAGS, 32'h1 << i);
            rdc(`IDX_PACKET_ERROR_FLAGS, 32'h0);
        end
    endtask
    task automatic lane_test();
        for (i = 0; i < 12; i++) begin
            k = i % 3;
            ev = '0;
            ev.sync_single[i / 3] = (k == 0);
            ev.sync_multi[i / 3] = (k == 1);
            ev.req_ctrl[i / 3] = (k == 2);
            ev_send();
            rdc(8'h5e + 8'(i / 6), 32'h1 << (((i / 3) % 2) * 4 + 3 - k));
        end
        ev = '0;
        ev.clk_ctrl = 1'b1;
        ev_send();
        rdc(`IDX_CLOCK_LANE, 32'h2);
    endtask
    task automatic header_test();
        ev = '0;
        ev.hdr_valid = 1'b1;
        ev.vc = 2'h2;
        ev.dt = 6'h2b;
        ev.wc = 16'h1234;
        ev.ecc = 6'h15;
        ev.len_change = 1'b1;
        ev_send();
        rdc(`IDX_HEADER_CHANNEL_TYPE, 32'hab);
        rdc(`IDX_HEADER_WC_LOW, 32'h34);
        rdc(`IDX_HEADER_WC_HIGH, 32'h12);
        rdc(`IDX_HEADER_ECC, 32'h95);
        ev.vc = 2'h1;
        ev.wc = 16'hbeef;
        ev.len_change = 1'b0;
        ev_send();
        rdc(`IDX_HEADER_CHANNEL_TYPE, 32'h6b);
        rdc(`IDX_HEADER_WC_HIGH, 32'hbe);
    endtask
    task automatic irq_test();
        bus(1'b1, `IDX_IRQ_STATUS, 32'h7f);
        ev = '0;
        ev.hdr_single = 1'b1;
        ev_send();
        rdc(`IDX_IRQ_STATUS, 32'h1);
        chk(irq, 32'h0);
        bus(1'b1, `IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq, 32'h1);
        bus(1'b1, `IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq, 32'h0);
    endtask
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        bad_count = 0;
        compares = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_values();
        count_test();
        flag_test();
        lane_test();
        header_test();
        irq_test();
        test_done();
    end
endmodule
